// ==== hdl/ufc_pkg.sv ====
// package for the serial port flow control and interrupt block
package ufc_pkg;
  // ********************************************
  // register offsets (byte addresses)
  // ********************************************
  localparam logic [11:0] port_control_reg_off      = 12'h030;
  localparam logic [11:0] fifo_level_select_reg_off = 12'h034;
  localparam logic [11:0] irq_mask_reg_off          = 12'h038;
  localparam logic [11:0] raw_irq_status_reg_off    = 12'h03c;
  localparam logic [11:0] masked_irq_status_reg_off = 12'h040;
  localparam logic [11:0] irq_clear_reg_off         = 12'h044;
  localparam logic [11:0] inband_flow_ctrl_reg_off  = 12'h050;
  localparam logic [11:0] resume_char_a_off         = 12'h054;
  localparam logic [11:0] resume_char_b_off         = 12'h058;
  localparam logic [11:0] pause_char_a_off          = 12'h05c;
  localparam logic [11:0] pause_char_b_off          = 12'h060;
  localparam logic [11:0] flag_reg_off              = 12'h064;
  // ********************************************
  // field positions
  // ********************************************
  localparam int cr_req_bit    = 14;
  localparam int cr_clear_bit  = 15;
  localparam int cr_enable_bit = 0;
  localparam int xf_on_bit     = 0;
  localparam int xf_rxmode_lsb = 1;
  localparam int xf_txmode_lsb = 3;
  localparam int xf_any_bit    = 5;
  localparam int xf_spec_bit   = 6;
  localparam int irq_done_bit  = 0;
  localparam int irq_pause_bit = 1;
  localparam int irq_rx_bit    = 2;
  localparam int irq_tx_bit    = 3;
  localparam int irq_tmo_bit   = 4;
  localparam int irq_err_bit   = 5;
  localparam int fr_stop_bit   = 0;
  // ********************************************
  // reset values and widths
  // ********************************************
  localparam logic [15:0] port_control_reset = 16'h0300;
  localparam logic [5:0]  level_select_reset = 6'h12;
  localparam int          lvl_w              = 6;
  // ********************************************
  // types
  // ********************************************
  typedef enum logic [1:0] {
    ufc_tx_idle  = 2'b00,
    ufc_tx_data  = 2'b01,
    ufc_tx_ctrl  = 2'b10
  } ufc_tx_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [3:0] err;
  } ufc_rx_char_t;

  typedef struct packed {
    logic [15:0]   ctrl;
    logic [5:0]    lvl;
    logic [5:0]    mask;
    logic [1:0]    raw;
    logic [6:0]    xf;
    logic [7:0]    res_a;
    logic [7:0]    res_b;
    logic [7:0]    pau_a;
    logic [7:0]    pau_b;
    logic          paused;
    logic          half_pause;
    logic          half_res;
    logic          stopped;
    logic          xf_was_on;
    logic          busy_q;
    logic [1:0]    cts_sync;
    ufc_tx_state_t tx_st;
    logic          tx_start;
    logic          tx_is_ctrl;
    logic [7:0]    tx_ctrl_char;
    logic          ctrl_second;
    logic          rx_store;
    ufc_rx_char_t  rx_out;
    logic          rts_n;
    logic          irq;
    logic          pready;
    logic [31:0]   prdata;
  } ufc_state_t;
endpackage : ufc_pkg

// ==== hdl/ufc_flow_irq.sv ====
// flow control and interrupt merge for the serial port
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
// Functional notes
// (RQ1) two control bits enable clear gating and request control independently
// (RQ2) request output held asserted while receive fill below watermark
// (RQ3) request reasserted once reads bring fill below watermark again
// (RQ4) remote stops after current char; without request control receive until full
// (RQ5) clear input sampled before each byte; start only when asserted with data
// (RQ6) clear dropping mid-character lets character finish, then transmission stops
// (RQ7) clear gating off: transmit until fifo empty, ignoring clear input
// (RQ8) receive mode selects pause/resume pair: off, first, second, both in sequence
// (RQ9) received pause match stops transmit after current char and sets pause status
// (RQ10) while suspended, resume match clears pause status and resumes transmit
// (RQ11) resume-on-any: any char resumes and is still stored
// (RQ12) matched pause/resume chars not stored, except special mode and resume-on-any
// (RQ13) matches accepted even with parity, framing or break error
// (RQ14) transmit mode field selects injected characters with same encoding
// (RQ15) rx fifo past trigger: inject pause char, set remote-stopped flag
// (RQ16) rx fifo back below trigger: inject resume char, clear remote-stopped flag
// (RQ17) in-band flow switched off after pause sent: send resume, clear flag
// (RQ18) software never enables both flow controls; polls flag before reading fifo
// (RQ19) special mode: compare with second pause char, set status, keep sending, store
// (RQ20) special status cleared only by writing one to the clear register bit
// (RQ21) six sources, each masked by a one bit, merged onto one line
// (RQ22) transmit-done raised when busy falls
// (RQ23) injected chars use the ordinary transmit framing settings
// (RQ24) request and clear lines active low, clear input double synchronised
module ufc_flow_irq (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // handshake pins
  output logic             req_n,
  input  wire logic        clear_n,
  // receive side
  input  wire ufc_pkg::ufc_rx_char_t rx_char,
  output ufc_pkg::ufc_rx_char_t      rx_fifo_wr,
  input  wire logic [4:0]  rx_fill,
  input  wire logic        rx_full,
  // transmit side
  input  wire logic        tx_fifo_empty,
  input  wire logic        tx_ready,
  input  wire logic        tx_busy,
  output logic             tx_start,
  output logic             tx_is_ctrl,
  output logic [7:0]       tx_ctrl_char,
  // other interrupt conditions
  input  wire logic [3:0]  ext_irq_raw,
  output logic             irq,
  output logic             port_enable
);
  ufc_pkg::ufc_state_t s;
  ufc_pkg::ufc_state_t next_s;

  logic       wr_acc;
  logic       rd_acc;
  logic [4:0] wmark;
  logic       above;
  logic [1:0] rxm;
  logic [1:0] txm;
  logic       xf_on;
  logic       spec;
  logic       any_res;
  logic       pause_hit;
  logic       res_hit;
  logic       tx_hold;
  logic [5:0] raw6;
  logic [7:0] c;
  logic       was_stopped;

  always_comb begin
    next_s     = s;
    wr_acc     = psel && penable && pwrite && s.pready;
    rd_acc     = psel && !penable && !pwrite;
    // watermark index: 1/8..7/8 of a 32 deep fifo
    case (s.lvl[5:3])
      3'd0:    wmark = 5'd4;
      3'd1:    wmark = 5'd8;
      3'd2:    wmark = 5'd16;
      3'd3:    wmark = 5'd24;
      default: wmark = 5'd28;
    endcase
    above      = (rx_fill >= wmark);
    xf_on      = s.xf[ufc_pkg::xf_on_bit] && !s.xf[ufc_pkg::xf_spec_bit];
    rxm        = xf_on ? s.xf[ufc_pkg::xf_rxmode_lsb +: 2] : 2'b00; // see (RQ8)
    txm        = xf_on ? s.xf[ufc_pkg::xf_txmode_lsb +: 2] : 2'b00; // see (RQ14)
    spec       = s.xf[ufc_pkg::xf_spec_bit];
    any_res    = s.xf[ufc_pkg::xf_any_bit];
    c          = rx_char.data;
    pause_hit  = 1'b0;
    res_hit    = 1'b0;
    // ********************************************
    // receive matching, error bits deliberately ignored
    // ********************************************
    next_s.rx_store = 1'b0;
    next_s.rx_out   = rx_char;
    if (rx_char.valid) begin // see (RQ13)
      next_s.rx_store = 1'b1;
      if (spec) begin
        if (c == s.pau_b) begin
          next_s.raw[1] = 1'b1; // see (RQ19)
        end
      end else begin
        case (rxm)
          2'b01: begin
            pause_hit = (c == s.pau_a);
            res_hit   = (c == s.res_a);
          end
          2'b10: begin
            pause_hit = (c == s.pau_b);
            res_hit   = (c == s.res_b);
          end
          2'b11: begin
            pause_hit = s.half_pause && (c == s.pau_b);
            res_hit   = s.half_res && (c == s.res_b);
            next_s.half_pause = (c == s.pau_a);
            next_s.half_res   = (c == s.res_a);
            // first half of a pair is a flow char as well, stored only when resume-on-any resumes
            next_s.rx_store   = !((c == s.pau_a) || (c == s.res_a)); // see (RQ12)
          end
          default: begin
          end
        endcase
        if (s.paused && any_res) begin
          next_s.paused   = 1'b0; // see (RQ11)
          next_s.raw[1]   = 1'b0;
          next_s.rx_store = 1'b1;
        end else if (pause_hit) begin
          next_s.paused   = 1'b1; // see (RQ9)
          next_s.raw[1]   = 1'b1;
          next_s.rx_store = 1'b0; // see (RQ12)
        end else if (res_hit) begin
          next_s.rx_store = 1'b0; // see (RQ12)
          if (s.paused) begin
            next_s.paused = 1'b0; // see (RQ10)
            next_s.raw[1] = 1'b0;
          end
        end
      end
    end
    if (rxm == 2'b00) begin
      next_s.paused = 1'b0;
    end
    // ********************************************
    // request line, active low
    // ********************************************
    next_s.rts_n = s.ctrl[ufc_pkg::cr_req_bit] && above; // see (RQ2) (RQ3) (RQ24)
    // ********************************************
    // transmit gating and control injection
    // ********************************************
    next_s.cts_sync = {s.cts_sync[0], clear_n}; // see (RQ24)
    tx_hold = (s.ctrl[ufc_pkg::cr_clear_bit] && s.cts_sync[1]) || s.paused; // see (RQ1) (RQ7)
    next_s.tx_start  = 1'b0;
    next_s.xf_was_on = xf_on;
    was_stopped = s.stopped;
    case (s.tx_st)
      ufc_pkg::ufc_tx_idle: begin
        if (tx_ready && s.ctrl[ufc_pkg::cr_enable_bit]) begin
          // control chars go first, past clear and pause gating
          if ((txm != 2'b00 && above && !s.stopped) ||
              (txm != 2'b00 && !above && s.stopped) ||
              (txm == 2'b00 && s.stopped)) begin // see (RQ15) (RQ16) (RQ17)
            next_s.tx_start     = 1'b1; // see (RQ23)
            next_s.tx_is_ctrl   = 1'b1;
            next_s.ctrl_second  = (s.xf_was_on ? 1'b0 : 1'b0);
            next_s.tx_ctrl_char = was_stopped ? ((txm == 2'b10) ? s.res_b : s.res_a)
                                              : ((txm == 2'b10) ? s.pau_b : s.pau_a);
            next_s.tx_st        = ufc_pkg::ufc_tx_ctrl;
          end else if (!tx_fifo_empty && !tx_hold) begin // see (RQ5)
            next_s.tx_start   = 1'b1;
            next_s.tx_is_ctrl = 1'b0;
            next_s.tx_st      = ufc_pkg::ufc_tx_data;
          end
        end
      end
      ufc_pkg::ufc_tx_data: begin
        // a running character always finishes, gating only acts at idle
        if (!tx_ready && !s.tx_start) begin // see (RQ6) (RQ4)
          next_s.tx_st = ufc_pkg::ufc_tx_idle;
        end else if (tx_ready && !s.tx_start) begin
          next_s.tx_st = ufc_pkg::ufc_tx_idle;
        end
      end
      ufc_pkg::ufc_tx_ctrl: begin
        // second char and flag only once the framer is free again
        if (!s.tx_start && tx_ready) begin
          if (s.tx_is_ctrl && txm == 2'b11 && !s.ctrl_second) begin
            next_s.tx_start     = 1'b1;
            next_s.ctrl_second  = 1'b1;
            next_s.tx_ctrl_char = s.stopped ? s.res_b : s.pau_b;
          end else begin
            next_s.stopped     = !s.stopped;
            next_s.ctrl_second = 1'b0;
            next_s.tx_is_ctrl  = 1'b0;
            next_s.tx_st       = ufc_pkg::ufc_tx_idle;
          end
        end
      end
      default: next_s.tx_st = ufc_pkg::ufc_tx_idle;
    endcase
    // ********************************************
    // interrupts
    // ********************************************
    next_s.busy_q = tx_busy;
    if (s.busy_q && !tx_busy) begin
      next_s.raw[0] = 1'b1; // see (RQ22)
    end
    // ********************************************
    // apb slave, no wait states, read data registered in the setup cycle
    // ********************************************
    next_s.pready = 1'b0;
    if (psel && !penable) begin
      next_s.pready = 1'b1;
    end
    if (wr_acc) begin
      case (paddr)
        ufc_pkg::port_control_reg_off:      next_s.ctrl  = pwdata[15:0];
        ufc_pkg::fifo_level_select_reg_off: next_s.lvl   = pwdata[5:0];
        ufc_pkg::irq_mask_reg_off:          next_s.mask  = pwdata[5:0];
        ufc_pkg::inband_flow_ctrl_reg_off:  next_s.xf    = pwdata[6:0];
        ufc_pkg::resume_char_a_off:         next_s.res_a = pwdata[7:0];
        ufc_pkg::resume_char_b_off:         next_s.res_b = pwdata[7:0];
        ufc_pkg::pause_char_a_off:          next_s.pau_a = pwdata[7:0];
        ufc_pkg::pause_char_b_off:          next_s.pau_b = pwdata[7:0];
        ufc_pkg::irq_clear_reg_off: begin
          // hardware set in the same cycle wins
          if (pwdata[0] && !(s.busy_q && !tx_busy)) begin
            next_s.raw[0] = 1'b0;
          end
          if (pwdata[1] && !(rx_char.valid && (pause_hit || (spec && c == s.pau_b)))) begin
            next_s.raw[1] = 1'b0; // see (RQ20)
          end
        end
        default: begin
        end
      endcase
    end
    raw6 = {ext_irq_raw, s.raw};
    next_s.irq = |(raw6 & s.mask); // see (RQ21)
    if (rd_acc) begin
      case (paddr)
        ufc_pkg::port_control_reg_off:      next_s.prdata = {16'h0000, s.ctrl};
        ufc_pkg::fifo_level_select_reg_off: next_s.prdata = {26'h0000000, s.lvl};
        ufc_pkg::irq_mask_reg_off:          next_s.prdata = {26'h0000000, s.mask};
        ufc_pkg::raw_irq_status_reg_off:    next_s.prdata = {26'h0000000, raw6};
        ufc_pkg::masked_irq_status_reg_off: next_s.prdata = {26'h0000000, raw6 & s.mask};
        ufc_pkg::inband_flow_ctrl_reg_off:  next_s.prdata = {25'h0000000, s.xf};
        ufc_pkg::resume_char_a_off:         next_s.prdata = {24'h000000, s.res_a};
        ufc_pkg::resume_char_b_off:         next_s.prdata = {24'h000000, s.res_b};
        ufc_pkg::pause_char_a_off:          next_s.prdata = {24'h000000, s.pau_a};
        ufc_pkg::pause_char_b_off:          next_s.prdata = {24'h000000, s.pau_b};
        ufc_pkg::flag_reg_off:              next_s.prdata = {31'h00000000, s.stopped};
        default:                            next_s.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.ctrl     <= ufc_pkg::port_control_reset;
      s.lvl      <= ufc_pkg::level_select_reset;
      s.cts_sync <= 2'b11;
      s.tx_st    <= ufc_pkg::ufc_tx_idle;
    end else begin
      s <= next_s;
    end
  end

  assign pready       = s.pready;
  assign prdata       = s.prdata;
  assign pslverr      = 1'b0;
  assign req_n        = s.rts_n;
  assign rx_fifo_wr   = '{valid: s.rx_store, data: s.rx_out.data, err: s.rx_out.err};
  assign tx_start     = s.tx_start;
  assign tx_is_ctrl   = s.tx_is_ctrl;
  assign tx_ctrl_char = s.tx_ctrl_char;
  assign irq          = s.irq;
  assign port_enable  = s.ctrl[ufc_pkg::cr_enable_bit];

  // ********************************************
  // assertions
  // ********************************************
  AST_REQ_WMARK: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ2)
    s.ctrl[ufc_pkg::cr_req_bit] && above |=> req_n)
    else $error("request not dropped at watermark");
  AST_REQ_OFF: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ1)
    !s.ctrl[ufc_pkg::cr_req_bit] |=> !req_n)
    else $error("request dropped while disabled");
  AST_CLEAR_GATE: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ5)
    tx_start && !tx_is_ctrl && $past(s.ctrl[ufc_pkg::cr_clear_bit]) |-> !$past(s.cts_sync[1]))
    else $error("data started while clear deasserted");
  AST_NO_EMPTY: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ7)
    tx_start && !tx_is_ctrl |-> !$past(tx_fifo_empty))
    else $error("data started from empty fifo");
  AST_PAUSE_SET: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ9)
    rx_char.valid && pause_hit && !(s.paused && any_res) |=> s.paused && s.raw[1])
    else $error("pause match ignored");
  AST_NOT_STORED: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ12)
    rx_char.valid && !spec && pause_hit && !(s.paused && any_res) |=> !rx_fifo_wr.valid)
    else $error("pause char stored");
  AST_DONE_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ22)
    $fell(tx_busy) |=> s.raw[0])
    else $error("transmit done not raised");
  AST_IRQ_MERGE: assert property (@(posedge pclk) disable iff (!presetn) // see (RQ21)
    ##1 irq == |({$past(ext_irq_raw), $past(s.raw)} & $past(s.mask)))
    else $error("interrupt merge wrong");
  COV_PAUSE: cover property (@(posedge pclk) disable iff (!presetn) s.paused ##[1:50] !s.paused);
  COV_INJECT: cover property (@(posedge pclk) disable iff (!presetn) tx_start && tx_is_ctrl);
  COV_REQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(req_n));
  COV_PAIR: cover property (@(posedge pclk) disable iff (!presetn) tx_start && s.ctrl_second);
endmodule : ufc_flow_irq

// ==== tb/ufc_remote.sv ====
// transmit framer model standing behind the start handshake
`timescale 1ns/100ps
module ufc_remote #(
  parameter int char_cyc = 40
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // start handshake from the block
  input  wire logic       tx_start,
  input  wire logic       tx_is_ctrl,
  input  wire logic [7:0] tx_ctrl_char,
  output logic            tx_busy,
  output logic            tx_ready,
  // observation for the bench
  output int              n_data,
  output int              n_ctrl,
  output logic [7:0]      last_ctrl
);
  // ********************************************
  // character timer
  // ********************************************
  int cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 0;
      n_data    <= 0;
      n_ctrl    <= 0;
      last_ctrl <= 8'h00;
    end else if (tx_start && cnt == 0) begin
      // control chars take the same frame as data
      cnt <= char_cyc;
      if (tx_is_ctrl) begin
        n_ctrl    <= n_ctrl + 1;
        last_ctrl <= tx_ctrl_char;
      end else begin
        n_data <= n_data + 1;
      end
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  // busy falls only once the last stop bit has left
  assign tx_busy  = (cnt != 0);
  assign tx_ready = (cnt == 0);
endmodule : ufc_remote

// ==== tb/ufc_flow_irq_tb.sv ====
// self-checking bench for the flow control and interrupt block
`timescale 1ns/100ps
module ufc_flow_irq_tb;
  // ********************************************
  // signals
  // ********************************************
  logic                  pclk = 1'b0;
  logic                  presetn, psel, penable, pwrite, pready, pslverr;
  logic                  req_n, clear_n, rx_full, tx_fifo_empty, tx_ready;
  logic                  tx_busy, tx_start, tx_is_ctrl, irq, port_enable;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata;
  logic [4:0]            rx_fill;
  logic [3:0]            ext_irq_raw;
  logic [7:0]            tx_ctrl_char, last_ctrl;
  ufc_pkg::ufc_rx_char_t rx_char, rx_fifo_wr;
  int                    n_errors = 0, comparisons = 0, cycles = 0, n_stored = 0;
  int                    n_data, n_ctrl, seed = 36122;
  localparam int         char_cyc = 40;
  localparam int         wm[5] = '{4, 8, 16, 24, 28};
  localparam logic [7:0] pa = 8'h13, pb = 8'h93, ra = 8'h11, rb = 8'h91;

  ufc_flow_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .req_n(req_n),
    .clear_n(clear_n), .rx_char(rx_char), .rx_fifo_wr(rx_fifo_wr), .rx_fill(rx_fill), .rx_full(rx_full),
    .tx_fifo_empty(tx_fifo_empty), .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_start(tx_start),
    .tx_is_ctrl(tx_is_ctrl), .tx_ctrl_char(tx_ctrl_char), .ext_irq_raw(ext_irq_raw), .irq(irq),
    .port_enable(port_enable));
  ufc_remote #(.char_cyc(char_cyc)) far (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
    .tx_is_ctrl(tx_is_ctrl), .tx_ctrl_char(tx_ctrl_char), .tx_busy(tx_busy), .tx_ready(tx_ready),
    .n_data(n_data), .n_ctrl(n_ctrl), .last_ctrl(last_ctrl));

  always #12.5 pclk = ~pclk;

  // cycle ceiling guards against a hang
  always @(posedge pclk) begin
    cycles++;
    if (rx_fifo_wr.valid === 1'b1) n_stored++;
    if (cycles == 60000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ********************************************
  // tasks
  // ********************************************
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e, "register read");
  endtask : rd

  task automatic raw(input int b, input logic e);
    rd(ufc_pkg::raw_irq_status_reg_off, 32'h1 << b, 32'(e) << b);
  endtask : raw

  task automatic wait_req(input logic e);
    int i;
    for (i = 0; i < 8 && req_n !== e; i++) @(posedge pclk);
    chk(32'(req_n), 32'(e), "request line");
  endtask : wait_req

  // error flags random: matching must ignore them
  task automatic send(input logic [7:0] d);
    rx_char <= '{1'b1, d, 4'($random(seed))};
    @(posedge pclk);
    rx_char <= '{1'b0, ~d, 4'hf};
    repeat (3) @(posedge pclk);
  endtask : send

  // let the char in flight end, then look for further starts
  task automatic txchk(input logic e);
    int n0;
    repeat (char_cyc + 8) @(posedge pclk);
    n0 = n_data;
    repeat (3 * char_cyc) @(posedge pclk);
    chk(32'(n_data != n0), 32'(e), "data flow");
  endtask : txchk

  task automatic inj(input int t, input logic [7:0] c, input logic f);
    int i;
    for (i = 0; i < 400 && n_ctrl < t; i++) @(posedge pclk);
    repeat (char_cyc + 8) @(posedge pclk);
    chk(32'(n_ctrl), 32'(t), "ctrl count");
    chk(32'(last_ctrl), 32'(c), "ctrl char");
    rd(ufc_pkg::flag_reg_off, 32'h1, 32'(f));
  endtask : inj
  // ********************************************
  // main sequence
  // ********************************************
  initial begin
    int m, k, n;
    logic [3:0] ext;
    logic [5:0] msk;
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_full, ext_irq_raw} = '0;
    {clear_n, rx_fill, tx_fifo_empty} = {1'b0, 5'h00, 1'b1};
    rx_char = '{1'b0, 8'h00, 4'h0};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ufc_pkg::port_control_reg_off, 32'hffffffff, 32'h300);
    rd(ufc_pkg::fifo_level_select_reg_off, 32'hffffffff, 32'h12);
    wr(12'h0fc, 32'hffffffff);
    rd(12'h0fc, 32'hffffffff, 32'h0);
    for (m = 0; m < 5; m++) begin
      wr(ufc_pkg::fifo_level_select_reg_off, 32'(m << 3) | 32'h2);
      wr(ufc_pkg::port_control_reg_off, 32'h4301);
      rx_fill <= 5'(wm[m] - 1);
      wait_req(1'b0);
      rx_fill <= 5'(wm[m]);
      wait_req(1'b1);
      rx_fill <= 5'(wm[m] - 1);
      wait_req(1'b0);
    end
    wr(ufc_pkg::port_control_reg_off, 32'h0301);
    rx_fill <= 5'h1f;
    wait_req(1'b0);
    chk(32'(port_enable), 32'h1, "port enable");
    rx_fill <= 5'h00;
    tx_fifo_empty <= 1'b0;
    clear_n <= 1'b1;
    wr(ufc_pkg::port_control_reg_off, 32'h8301);
    txchk(1'b0);
    clear_n <= 1'b0;
    txchk(1'b1);
    for (k = 0; k < 200 && tx_start !== 1'b1; k++) @(posedge pclk);
    clear_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(tx_busy), 32'h1, "char finishes");
    txchk(1'b0);
    wr(ufc_pkg::port_control_reg_off, 32'h0301);
    txchk(1'b1);
    tx_fifo_empty <= 1'b1;
    txchk(1'b0);
    tx_fifo_empty <= 1'b0;
    wr(ufc_pkg::pause_char_a_off, 32'(pa));
    wr(ufc_pkg::pause_char_b_off, 32'(pb));
    wr(ufc_pkg::resume_char_a_off, 32'(ra));
    wr(ufc_pkg::resume_char_b_off, 32'(rb));
    for (m = 0; m < 4; m++) begin
      wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'(1 | (m << 1)));
      k = n_stored;
      if (m != 2) send(pa);
      if (m != 1) send(pb);
      chk(32'(n_stored - k), (m == 0) ? 32'h2 : 32'h0, "pause stored");
      raw(1, m != 0);
      txchk(m == 0);
      if (m != 2) send(ra);
      if (m != 1) send(rb);
      chk(32'(n_stored - k), (m == 0) ? 32'h4 : 32'h0, "resume stored");
      raw(1, 1'b0);
      txchk(1'b1);
    end
    wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'h23);
    send(pa);
    raw(1, 1'b1);
    k = n_stored;
    send(8'h41);
    chk(32'(n_stored - k), 32'h1, "any stored");
    raw(1, 1'b0);
    txchk(1'b1);
    for (m = 0; m < 4; m++) begin
      wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'(1 | (m << 3)));
      k = n_ctrl;
      n = (m == 3) ? 2 : int'(m != 0);
      rx_fill <= 5'h1f;
      inj(k + n, (m == 0) ? 8'h00 : (m == 1) ? pa : pb, m != 0);
      rx_fill <= 5'h00;
      inj(k + 2 * n, (m == 0) ? 8'h00 : (m == 1) ? ra : rb, 1'b0);
    end
    wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'h09);
    k = n_ctrl;
    rx_fill <= 5'h1f;
    inj(k + 1, pa, 1'b1);
    wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'h00);
    inj(k + 2, ra, 1'b0);
    rx_fill <= 5'h00;
    wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'h40);
    k = n_stored;
    send(pb);
    chk(32'(n_stored - k), 32'h1, "special stored");
    raw(1, 1'b1);
    txchk(1'b1);
    send(ra);
    raw(1, 1'b1);
    wr(ufc_pkg::irq_clear_reg_off, 32'h2);
    raw(1, 1'b0);
    wr(ufc_pkg::inband_flow_ctrl_reg_off, 32'h00);
    tx_fifo_empty <= 1'b1;
    repeat (char_cyc + 8) @(posedge pclk);
    wr(ufc_pkg::irq_clear_reg_off, 32'h3f);
    for (m = 0; m < 8; m++) begin
      ext = 4'($random(seed));
      msk = {4'($random(seed)), 2'b00};
      ext_irq_raw <= ext;
      wr(ufc_pkg::irq_mask_reg_off, 32'(msk));
      rd(ufc_pkg::masked_irq_status_reg_off, 32'h3c, 32'(ext & msk[5:2]) << 2);
      rd(ufc_pkg::raw_irq_status_reg_off, 32'h3c, 32'(ext) << 2);
      chk(32'(irq), 32'(|(ext & msk[5:2])), "irq line");
    end
    ext_irq_raw <= 4'h0;
    wr(ufc_pkg::irq_mask_reg_off, 32'h1);
    tx_fifo_empty <= 1'b0;
    for (k = 0; k < 200 && tx_busy !== 1'b1; k++) @(posedge pclk);
    tx_fifo_empty <= 1'b1;
    wr(ufc_pkg::irq_clear_reg_off, 32'h1);
    raw(0, 1'b0);
    for (k = 0; k < 200 && tx_busy !== 1'b0; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    raw(0, 1'b1);
    chk(32'(irq), 32'h1, "done irq");
    end_of_test();
  end
endmodule : ufc_flow_irq_tb
